// ### inc/timer_defines.vh
// Register offsets, field positions, reset values and counts of the timer.
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// Byte offsets of the register words.
`define TMR_OFF_CTRL        8'h00
`define TMR_OFF_COUNT       8'h04
`define TMR_OFF_PRESC       8'h08
`define TMR_OFF_EVT_STATUS  8'h0c
`define TMR_OFF_EVT_MASK    8'h10

////////////////////////////////////////////////////////////////////////////
// Field positions in the control and status word.
`define TMR_BIT_ZERO_FLAG   7
`define TMR_BIT_IRQ_EN      6
`define TMR_BIT_PIN_DIR     5
`define TMR_BIT_DATA_OUT    4
`define TMR_BIT_RUN         3
`define TMR_TAP_HI          2
`define TMR_TAP_LO          0

////////////////////////////////////////////////////////////////////////////
// Reset values.
`define TMR_RST_COUNT       8'hff
`define TMR_RST_PRESC       7'h7f
`define TMR_RST_CTRL        8'h00

////////////////////////////////////////////////////////////////////////////
// Timing: internal clock divided by twelve feeds the prescaler.
`define TMR_INT_DIV         12
`define TMR_DIV_W           4

////////////////////////////////////////////////////////////////////////////
// Bus answers.
`define TMR_RESP_OKAY       2'b00
`define TMR_RESP_SLVERR     2'b10

`endif

// ### logic/pin_sync.v
// Two-stage synchroniser for the timer pin input.
`default_nettype none

module pin_sync (
  // Clock and reset
  input  wire mclk_i,
  input  wire reset_i,
  // Raw and synchronised level
  input  wire async_i,
  output wire sync_o
);

  reg stage1_ff;
  reg stage2_ff;

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end else begin
      stage1_ff <= async_i;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_o = stage2_ff;

endmodule

`default_nettype wire

// ### logic/prescaled_down_counter_timer.v
// Prescaled 8-bit down-counter timer with an AXI4-Lite register slave.
//
// Summary of operation
// - Counter decrements on each selected tap rise.
// - Count loadable and readable; prescaler state readable.
// - Decrement to zero sets the zero flag.
// - Enable and zero flag raise timer request.
// - Request wakes core; counting continues past zero.
// - Prescaler clocked by divide-by-12 or pin.
// - Tap select routes input or prescaler bit.
// - Run bit low forces prescaler ones, stops.
// - Running prescaler loadable with 0 to 7Fh.
// - Gated mode counts divided clock while pin high.
// - Event mode counts timer pin rising edges.
// - Output mode drives pin, counts divided clock.
// - Pin follows data bit while flag high.
// - Tap codes give ratios 1 to 128.
// - Count write beats coincident zero decrement.
// - Reset loads FFh, 7Fh, clears control.
`default_nettype none
`include "timer_defines.vh"

module prescaled_down_counter_timer #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input  wire              mclk_i,
  input  wire              reset_i,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output wire              s_axi_awready_o,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output wire              s_axi_wready_o,
  // AXI4-Lite write response
  output wire [1:0]        s_axi_bresp_o,
  output wire              s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output wire              s_axi_arready_o,
  // AXI4-Lite read data
  output wire [31:0]       s_axi_rdata_o,
  output wire [1:0]        s_axi_rresp_o,
  output wire              s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  // Timer pin
  input  wire              timer_pin_i,
  output wire              timer_pin_o,
  output wire              timer_pin_oe_o,
  // Interrupts
  output wire              timer_irq_o,
  output wire              irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  // True when a bus address selects the given word.
  function addr_hit;
    input [ADDR_W-1:0] addr;
    input [7:0]        off;
    begin
      addr_hit = ({addr[ADDR_W-1:2], 2'b00} == off[ADDR_W-1:0]);
    end
  endfunction

  // True when the selected tap rises on this prescaler step.
  function tap_rise;
    input [6:0] old_val;
    input [6:0] new_val;
    input [2:0] sel;
    integer     idx;
    begin
      idx = 0;
      if (sel == 3'h0) begin
        tap_rise = 1'b1;
      end else begin
        idx      = sel - 1;
        tap_rise = ~old_val[idx] & new_val[idx];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  reg                  zero_flag_ff;
  reg                  zero_irq_enable_ff;
  reg                  pin_direction_select_ff;
  reg                  data_out_ff;
  reg                  prescaler_run_ff;
  reg [2:0]            tap_select_ff;
  reg [7:0]            count_ff;
  reg [6:0]            presc_ff;
  reg [`TMR_DIV_W-1:0] div_cnt_ff;
  reg                  pin_prev_ff;
  reg                  timer_pin_ff;
  reg                  evt_status_ff;
  reg                  evt_mask_ff;
  // Bus state.
  reg                  aw_held_ff;
  reg [ADDR_W-1:0]     awaddr_ff;
  reg                  w_held_ff;
  reg [7:0]            wdata_ff;
  reg                  wstrb0_ff;
  reg                  bvalid_ff;
  reg [1:0]            bresp_ff;
  reg                  rvalid_ff;
  reg [31:0]           rdata_ff;
  reg [1:0]            rresp_ff;
  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel.
  assign s_axi_awready_o = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready_o  = ~w_held_ff & ~bvalid_ff;
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;

  // Address and data may arrive in either order; both are held first.
  wire do_write  = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire wr_en     = do_write & wstrb0_ff;
  wire wr_ctrl   = wr_en & addr_hit(awaddr_ff, `TMR_OFF_CTRL);
  wire wr_count  = wr_en & addr_hit(awaddr_ff, `TMR_OFF_COUNT);
  wire wr_presc  = wr_en & addr_hit(awaddr_ff, `TMR_OFF_PRESC);
  wire wr_status = wr_en & addr_hit(awaddr_ff, `TMR_OFF_EVT_STATUS);
  wire wr_mask   = wr_en & addr_hit(awaddr_ff, `TMR_OFF_EVT_MASK);
  wire wr_mapped = addr_hit(awaddr_ff, `TMR_OFF_CTRL)
                 | addr_hit(awaddr_ff, `TMR_OFF_COUNT)
                 | addr_hit(awaddr_ff, `TMR_OFF_PRESC)
                 | addr_hit(awaddr_ff, `TMR_OFF_EVT_STATUS)
                 | addr_hit(awaddr_ff, `TMR_OFF_EVT_MASK);

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= {ADDR_W{1'b0}};
      w_held_ff  <= 1'b0;
      wdata_ff   <= 8'h00;
      wstrb0_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `TMR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata_i[7:0];
        wstrb0_ff <= s_axi_wstrb_i[0];
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_mapped ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      end else if (bvalid_ff & s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.
  reg [31:0] rd_mux;
  reg        rd_hit;
  assign s_axi_arready_o = ~rvalid_ff;
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rdata_o   = rdata_ff;
  assign s_axi_rresp_o   = rresp_ff;

  // Bit 7 of the prescaler word always reads as zero.
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (addr_hit(s_axi_araddr_i, `TMR_OFF_CTRL)) begin
      rd_mux[7:0] = {zero_flag_ff, zero_irq_enable_ff,
                     pin_direction_select_ff, data_out_ff,
                     prescaler_run_ff, tap_select_ff};
    end else if (addr_hit(s_axi_araddr_i, `TMR_OFF_COUNT)) begin
      rd_mux[7:0] = count_ff;
    end else if (addr_hit(s_axi_araddr_i, `TMR_OFF_PRESC)) begin
      rd_mux[7:0] = {1'b0, presc_ff};
    end else if (addr_hit(s_axi_araddr_i, `TMR_OFF_EVT_STATUS)) begin
      rd_mux[0] = evt_status_ff;
    end else if (addr_hit(s_axi_araddr_i, `TMR_OFF_EVT_MASK)) begin
      rd_mux[0] = evt_mask_ff;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `TMR_RESP_OKAY;
    end else if (s_axi_arvalid_i & s_axi_arready_o) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_hit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
    end else if (rvalid_ff & s_axi_rready_i) begin
      rvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer pin input and clock sources.
  wire pin_level;
  reg  presc_in_evt;

  pin_sync u_pin_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i (timer_pin_i),
    .sync_o  (pin_level)
  );

  wire pin_rise = pin_level & ~pin_prev_ff;
  wire tick_div = (div_cnt_ff == (`TMR_INT_DIV - 1));

  // The divider runs free so that the first tick after a start is at most
  // twelve clocks away; a restart would bias short gate measurements.
  always @* begin
    if (pin_direction_select_ff) begin
      presc_in_evt = tick_div;
    end else if (data_out_ff) begin
      presc_in_evt = tick_div & pin_level;
    end else begin
      presc_in_evt = pin_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and counter.
  // prescaler steps on source edge
  wire       presc_dec     = prescaler_run_ff & presc_in_evt;
  wire [6:0] presc_dec_val = presc_ff - 7'h01;

  wire count_clk = presc_dec
                 & tap_rise(presc_ff, presc_dec_val, tap_select_ff);

  wire zero_evt = count_clk & (count_ff == 8'h01) & ~wr_count;

  // Writing zero to the count also raises the flag.
  wire zero_set = zero_evt | (wr_count & (wdata_ff == 8'h00));
  reg [7:0] nxt_count;
  reg [6:0] nxt_presc;
  reg       nxt_zero_flag;
  reg       nxt_data_out;

  always @* begin
    nxt_count = count_ff;
    if (wr_count) begin
      nxt_count = wdata_ff;
    end else if (count_clk) begin
      nxt_count = count_ff - 8'h01;
    end
  end

  always @* begin
    nxt_presc = presc_ff;
    if (!prescaler_run_ff) begin
      nxt_presc = `TMR_RST_PRESC;
    end else if (wr_presc) begin
      nxt_presc = wdata_ff[6:0];
    end else if (presc_dec) begin
      nxt_presc = presc_dec_val;
    end
  end

  // A hardware set wins over a software clear in the same cycle.
  always @* begin
    nxt_data_out = wr_ctrl ? wdata_ff[`TMR_BIT_DATA_OUT] : data_out_ff;
    if (wr_ctrl) begin
      nxt_zero_flag = wdata_ff[`TMR_BIT_ZERO_FLAG] | zero_set;
    end else begin
      nxt_zero_flag = zero_flag_ff | zero_set;
    end
  end

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      count_ff                <= `TMR_RST_COUNT;
      presc_ff                <= `TMR_RST_PRESC;
      zero_flag_ff            <= 1'b0;
      zero_irq_enable_ff      <= 1'b0;
      pin_direction_select_ff <= 1'b0;
      data_out_ff             <= 1'b0;
      prescaler_run_ff        <= 1'b0;
      tap_select_ff           <= 3'h0;
      div_cnt_ff              <= {`TMR_DIV_W{1'b0}};
      pin_prev_ff             <= 1'b0;
      timer_pin_ff            <= 1'b0;
    end else begin
      count_ff     <= nxt_count;
      presc_ff     <= nxt_presc;
      zero_flag_ff <= nxt_zero_flag;
      data_out_ff  <= nxt_data_out;
      pin_prev_ff  <= pin_level;
      if (tick_div) begin
        div_cnt_ff <= {`TMR_DIV_W{1'b0}};
      end else begin
        div_cnt_ff <= div_cnt_ff + 1'b1;
      end
      if (wr_ctrl) begin
        zero_irq_enable_ff      <= wdata_ff[`TMR_BIT_IRQ_EN];
        pin_direction_select_ff <= wdata_ff[`TMR_BIT_PIN_DIR];
        prescaler_run_ff        <= wdata_ff[`TMR_BIT_RUN];
        tap_select_ff           <= wdata_ff[`TMR_TAP_HI:`TMR_TAP_LO];
      end
      if (nxt_zero_flag) begin
        timer_pin_ff <= nxt_data_out;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and interrupts.
  // drive pin in output mode
  assign timer_pin_o    = timer_pin_ff;
  assign timer_pin_oe_o = pin_direction_select_ff;

  // request is a level usable for wake-up
  assign timer_irq_o = zero_irq_enable_ff & zero_flag_ff;
  // Sticky event bit: write one clears, a new zero event wins.
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      evt_status_ff <= 1'b0;
      evt_mask_ff   <= 1'b0;
    end else begin
      if (zero_evt) begin
        evt_status_ff <= 1'b1;
      end else if (wr_status & wdata_ff[0]) begin
        evt_status_ff <= 1'b0;
      end
      if (wr_mask) begin
        evt_mask_ff <= wdata_ff[0];
      end
    end
  end

  assign irq_o = evt_status_ff & evt_mask_ff;

endmodule

`default_nettype wire

// ### tb/timer_chk_sva.sv
// Port-level timing checker for the prescaled down-counter timer.
`default_nettype none
module timer_chk (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        reset_i,
  // Register bus handshakes
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  // Pin and requests
  input wire logic        timer_pin_oe_o,
  input wire logic        timer_irq_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  chk_write_lat: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write answer not two cycles after request");
  chk_read_lat: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o) else $error("read answer late");
  chk_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped early");
  chk_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped early");
  chk_b_block: assert property (s_axi_bvalid_o
    |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("new write taken during answer");
  chk_r_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("new read taken during answer");
  chk_oe_write: assert property ($changed(timer_pin_oe_o)
    |-> $rose(s_axi_bvalid_o)) else $error("pin direction moved alone");
  chk_irq_clear: assert property ($fell(timer_irq_o)
    |-> $rose(s_axi_bvalid_o)) else $error("timer request fell alone");
  chk_evt_clear: assert property ($fell(irq_o)
    |-> $rose(s_axi_bvalid_o)) else $error("event request fell alone");
  cov_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
  cov_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
  cov_irq: cover property ($rose(timer_irq_o));
endmodule
bind prescaled_down_counter_timer timer_chk i_chk (.*);
`default_nettype wire

// ### tb/pin_source.sv
// Signal source on the timer pin: idle level or a burst of pulses.
`default_nettype none
module pin_source (
  // Clock
  input wire logic       mclk_i,
  // Idle level and burst request
  input wire logic       lvl_i,
  input wire logic       start_i,
  input wire logic [7:0] n_i,
  // Pin drive and activity
  output logic           pin_o,
  output logic           busy_o
);
  logic [7:0] left_ff = 8'h00;
  logic [2:0] ph_ff = 3'h0;
  // Pulses last four cycles so the synchroniser never misses an edge.
  assign busy_o = left_ff != 8'h00;
  assign pin_o  = busy_o ? ph_ff[2] : lvl_i;
  always @(posedge mclk_i) begin
    if (start_i) begin
      left_ff <= n_i;
      ph_ff   <= 3'h0;
    end else if (busy_o) begin
      ph_ff <= ph_ff + 3'h1;
      if (ph_ff == 3'h7) begin
        left_ff <= left_ff - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the prescaled down-counter timer.
`default_nettype none
`include "timer_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, lvl = 1'b0, start = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rd_q, p1, d;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         pin_o, pin_oe, src_pin, busy, timer_irq, irq;
  wire         pin = pin_oe ? pin_o : src_pin;
  logic [1:0]  wq[$];
  logic [34:0] rq[$];
  logic [34:0] e;
  int          errors = 0, cmp_count = 0, t, n;
  integer      seed = 32'h788b260c;

  initial forever #2.5 clk = ~clk;

  prescaled_down_counter_timer #(.ADDR_W(8)) i_dut (
    .mclk_i (clk), .reset_i (rst),
    .s_axi_awaddr_i (awaddr), .s_axi_awvalid_i (awvalid),
    .s_axi_awready_o (awready), .s_axi_wdata_i (wdata),
    .s_axi_wstrb_i (wstrb), .s_axi_wvalid_i (wvalid),
    .s_axi_wready_o (wready), .s_axi_bresp_o (bresp),
    .s_axi_bvalid_o (bvalid), .s_axi_bready_i (bready),
    .s_axi_araddr_i (araddr), .s_axi_arvalid_i (arvalid),
    .s_axi_arready_o (arready), .s_axi_rdata_o (rdata),
    .s_axi_rresp_o (rresp), .s_axi_rvalid_o (rvalid),
    .s_axi_rready_i (rready), .timer_pin_i (pin),
    .timer_pin_o (pin_o), .timer_pin_oe_o (pin_oe),
    .timer_irq_o (timer_irq), .irq_o (irq));

  pin_source i_src (
    .mclk_i (clk), .lvl_i (lvl), .start_i (start), .n_i (8'h07),
    .pin_o (src_pin), .busy_o (busy));

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic give_up;
    errors++;
    print_verdict;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Every task starts on a fresh edge so no strobe is driven twice at once.
  task automatic wr(input logic [7:0] a, input logic [7:0] dat,
                    input logic [1:0] r = `TMR_RESP_OKAY);
    int k;
    @(posedge clk);
    wq.push_back(r);
    awaddr <= a;
    wdata <= {24'h0, dat};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (k == 50) give_up;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] dat,
                    input logic care = 1'b1,
                    input logic [1:0] r = `TMR_RESP_OKAY);
    int k;
    @(posedge clk);
    rq.push_back({care, r, 24'h0, dat});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd_q = rdata[7:0];
    rready <= 1'b0;
    if (k == 50) give_up;
  endtask

  // Answers are compared against the oldest note in arrival order.
  always @(posedge clk) begin
    if (bvalid === 1'b1 && bready === 1'b1) begin
      check(32'(bresp), 32'(wq.pop_front()));
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = rq.pop_front();
      check(32'(rresp), 32'(e[33:32]));
      if (e[34]) check(rdata, e[31:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`TMR_OFF_CTRL, `TMR_RST_CTRL);
    rd(`TMR_OFF_COUNT, `TMR_RST_COUNT);
    rd(`TMR_OFF_PRESC, {1'b0, `TMR_RST_PRESC});
    rd(8'h14, 8'h00, 1'b1, `TMR_RESP_SLVERR);
    wr(8'h14, 8'h5a, `TMR_RESP_SLVERR);
    for (t = 0; t < 4; t++) begin
      d = 8'($random(seed));
      wr(`TMR_OFF_COUNT, d);
      rd(`TMR_OFF_COUNT, d);
    end
    // A stopped prescaler ignores loads and stays at all ones.
    wr(`TMR_OFF_PRESC, 8'h11);
    repeat (60) @(posedge clk);
    // A write without its low byte lane answers but changes nothing.
    wstrb <= 4'h0;
    wr(`TMR_OFF_COUNT, 8'hc3);
    wstrb <= 4'hf;
    rd(`TMR_OFF_COUNT, d);
    rd(`TMR_OFF_PRESC, 8'h7f);
    wr(`TMR_OFF_CTRL, 8'h18);
    wr(`TMR_OFF_PRESC, 8'h55);
    rd(`TMR_OFF_PRESC, 8'h55);
    lvl <= 1'b1;
    repeat (120) @(posedge clk);
    lvl <= 1'b0;
    repeat (10) @(posedge clk);
    rd(`TMR_OFF_PRESC, 8'h00, 1'b0);
    p1 = rd_q;
    d = 8'h55 - p1;
    check(32'(d >= 8'd9 && d <= 8'd11), 32'h1);
    repeat (100) @(posedge clk);
    rd(`TMR_OFF_PRESC, p1);
    wr(`TMR_OFF_CTRL, 8'h00);
    wr(`TMR_OFF_COUNT, 8'h20);
    wr(`TMR_OFF_CTRL, 8'h08);
    wr(`TMR_OFF_PRESC, 8'h10);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    for (n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk);
    if (n == 100) give_up;
    repeat (6) @(posedge clk);
    rd(`TMR_OFF_PRESC, 8'h09);
    rd(`TMR_OFF_COUNT, 8'h19);
    // The synced pin edge lands on the very cycle the count load applies.
    wr(`TMR_OFF_COUNT, 8'h01);
    wr(`TMR_OFF_EVT_STATUS, 8'h01);
    lvl <= 1'b1;
    wr(`TMR_OFF_COUNT, 8'h05);
    lvl <= 1'b0;
    rd(`TMR_OFF_COUNT, 8'h05);
    rd(`TMR_OFF_CTRL, 8'h08);
    rd(`TMR_OFF_EVT_STATUS, 8'h00);
    // Two decrements from a fresh prescaler take twice the tap ratio.
    for (t = 0; t < 8; t++) begin
      wr(`TMR_OFF_CTRL, 8'h00);
      wr(`TMR_OFF_COUNT, 8'h02);
      wr(`TMR_OFF_CTRL, {5'b01101, t[2:0]});
      for (n = 0; n < 4000 && timer_irq !== 1'b1; n++) @(posedge clk);
      if (n == 4000) give_up;
      check(32'(n >= (24 << t) - 16 && n <= (24 << t) + 8), 32'h1);
      check(32'(pin_oe), 32'h1);
    end
    wr(`TMR_OFF_CTRL, 8'hb8);
    check(32'(pin_o), 32'h1);
    wr(`TMR_OFF_CTRL, 8'h28);
    check(32'(pin_o), 32'h1);
    check(32'(timer_irq), 32'h0);
    wr(`TMR_OFF_CTRL, 8'hf8);
    check(32'(timer_irq), 32'h1);
    // Software clears the flag while servicing the request.
    wr(`TMR_OFF_CTRL, 8'h78);
    check(32'(timer_irq), 32'h0);
    wr(`TMR_OFF_EVT_MASK, 8'h01);
    check(32'(irq), 32'h1);
    wr(`TMR_OFF_EVT_MASK, 8'h00);
    check(32'(irq), 32'h0);
    wr(`TMR_OFF_EVT_STATUS, 8'h01);
    wr(`TMR_OFF_EVT_MASK, 8'h01);
    check(32'(irq), 32'h0);
    print_verdict;
  end
endmodule
`default_nettype wire
